// *** hw/ccpd_clock_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

module ccpd_clock_ctrl (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_clock_mode_pin_a,
  input wire logic i_clock_mode_pin_b,
  input wire logic i_external_ref_input,
  input wire logic i_crystal_input,
  input wire logic i_reset_pin_n,
  input wire logic [ccpd_pkg::CCPD_INT_W-1:0] i_int_pin_n,
  input wire logic [1:0] i_divide_sel,
  input wire logic i_legacy_div2,
  output logic o_crystal_drive_output,
  output logic o_pll_power_enable,
  output logic o_feedback_enable,
  output logic o_pll_locked,
  output logic o_clock_stopped,
  output logic o_primary_phase_clock,
  output logic o_secondary_phase_clock
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] mode_s1_q, mode_s2_q;
  logic ext_s1_q, ext_s2_q, xtal_s1_q, xtal_s2_q;
  logic rstp_s1_q, rstp_s2_q;
  logic [ccpd_pkg::CCPD_INT_W-1:0] int_s1_q, int_s2_q;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      mode_s1_q <= 2'h0;
      mode_s2_q <= 2'h0;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      xtal_s1_q <= 1'b0;
      xtal_s2_q <= 1'b0;
      rstp_s1_q <= 1'b0;
      rstp_s2_q <= 1'b0;
      int_s1_q <= {ccpd_pkg::CCPD_INT_W{1'b1}};
      int_s2_q <= {ccpd_pkg::CCPD_INT_W{1'b1}};
    end else begin
      mode_s1_q <= {i_clock_mode_pin_a, i_clock_mode_pin_b};
      mode_s2_q <= mode_s1_q;
      ext_s1_q <= i_external_ref_input;
      ext_s2_q <= ext_s1_q;
      xtal_s1_q <= i_crystal_input;
      xtal_s2_q <= xtal_s1_q;
      rstp_s1_q <= i_reset_pin_n;
      rstp_s2_q <= rstp_s1_q;
      int_s1_q <= i_int_pin_n;
      int_s2_q <= int_s1_q;
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  ccpd_pkg::ccpd_mode_t mode;
  always_comb begin
    mode.feedback_on = 1'b1;
    mode.pll_power = 1'b0;
    mode.ratio = ccpd_pkg::ccpd_ratio_one;
    unique case (mode_s2_q)
      ccpd_pkg::CCPD_MODE_STATIC: begin
        mode.feedback_on = 1'b0;
      end
      ccpd_pkg::CCPD_MODE_HALF: begin
        mode.ratio = ccpd_pkg::ccpd_ratio_half;
      end
      ccpd_pkg::CCPD_MODE_ONE: begin
        mode.ratio = ccpd_pkg::ccpd_ratio_one;
      end
      ccpd_pkg::CCPD_MODE_PLL: begin
        mode.pll_power = 1'b1;
        mode.ratio = ccpd_pkg::ccpd_ratio_five;
      end
    endcase
  end

  // ----------------------------------------
  // reference and edge detection
  // ----------------------------------------
  logic ref_q, rstp_q, half_q;
  wire ref_now = ext_s2_q ^ xtal_s2_q;
  wire ref_edge = ref_now && !ref_q;
  wire rstp_fall = rstp_q && !rstp_s2_q;
  wire sync_clr = rstp_fall && ref_edge;
  wire half_tick = ref_edge && half_q;

  // ----------------------------------------
  // PLL model: period measure, lock, x5
  // ----------------------------------------
  logic [ccpd_pkg::CCPD_PER_W-1:0] per_cnt_q, per_q, acc_q;
  logic [7:0] lock_cnt_q;
  ccpd_pkg::ccpd_lock_t lock_q;
  wire [ccpd_pkg::CCPD_PER_W-1:0] acc_sum = acc_q + ccpd_pkg::CCPD_PLL_MULT;
  wire acc_wrap = (per_q != '0) && (acc_sum >= per_q);
  wire x5_tick = acc_wrap;
  wire pll_tick = (lock_q == ccpd_pkg::ccpd_lock_track) ? x5_tick : half_tick;
  wire lock_adv = ref_edge && rstp_s2_q && mode.pll_power;
  logic core_tick;

  always_comb begin
    unique case (mode.ratio)
      ccpd_pkg::ccpd_ratio_five: core_tick = pll_tick;
      ccpd_pkg::ccpd_ratio_half: core_tick = half_tick;
      ccpd_pkg::ccpd_ratio_one: core_tick = ref_edge;
      default: core_tick = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ref_q <= 1'b0;
      rstp_q <= 1'b0;
      half_q <= 1'b0;
      per_cnt_q <= '0;
      per_q <= '0;
      acc_q <= '0;
      lock_cnt_q <= 8'h00;
      lock_q <= ccpd_pkg::ccpd_lock_ramp;
    end else begin
      ref_q <= ref_now;
      rstp_q <= rstp_s2_q;
      if (ref_edge) begin
        half_q <= !half_q;
      end
      if (!mode.pll_power) begin
        per_cnt_q <= '0;
        per_q <= '0;
        acc_q <= '0;
        lock_cnt_q <= 8'h00;
        lock_q <= ccpd_pkg::ccpd_lock_ramp;
      end else begin
        // tracks the latest reference period
        if (ref_edge) begin
          per_q <= per_cnt_q + 16'h0001;
          per_cnt_q <= '0;
          acc_q <= '0;
        end else begin
          per_cnt_q <= per_cnt_q + 16'h0001;
          acc_q <= acc_wrap ? acc_sum - per_q : acc_sum;
        end
        if (lock_adv && lock_q == ccpd_pkg::ccpd_lock_ramp) begin
          lock_cnt_q <= lock_cnt_q + 8'h01;
          if (lock_cnt_q == ccpd_pkg::CCPD_LOCK_LAST) begin
            lock_q <= ccpd_pkg::ccpd_lock_track;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // divider and phase outputs
  // ----------------------------------------
  logic div_tick, stopped, leg_q, phase_q;
  wire wake = !rstp_s2_q || (int_s2_q != {ccpd_pkg::CCPD_INT_W{1'b1}});
  wire ccpd_pkg::ccpd_div_t div_sel = ccpd_pkg::ccpd_div_t'(i_divide_sel);

  ccpd_divider u_div (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_tick(core_tick),
    .i_sel(div_sel),
    .i_wake(wake),
    .i_sync_clr(sync_clr),
    .o_tick(div_tick),
    .o_stopped(stopped)
  );

  // phases toggle only on whole ticks, never mid-period
  wire phase_step = div_tick && (!i_legacy_div2 || leg_q);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      leg_q <= 1'b0;
      phase_q <= 1'b0;
      o_crystal_drive_output <= 1'b0;
      o_pll_power_enable <= 1'b0;
      o_feedback_enable <= 1'b0;
      o_pll_locked <= 1'b0;
      o_clock_stopped <= 1'b0;
      o_primary_phase_clock <= 1'b0;
      o_secondary_phase_clock <= 1'b1;
    end else begin
      if (sync_clr) begin
        leg_q <= 1'b0;
        phase_q <= 1'b0;
      end else begin
        if (div_tick) begin
          leg_q <= !leg_q;
        end
        if (phase_step) begin
          phase_q <= !phase_q;
        end
      end
      o_crystal_drive_output <= mode.feedback_on && !xtal_s2_q;
      o_pll_power_enable <= mode.pll_power;
      o_feedback_enable <= mode.feedback_on;
      o_pll_locked <= mode.pll_power && (lock_q == ccpd_pkg::ccpd_lock_track);
      o_clock_stopped <= stopped;
      o_primary_phase_clock <= phase_q;
      o_secondary_phase_clock <= !phase_q;
    end
  end

endmodule

`default_nettype wire

// *** hw/ccpd_pkg.sv ***
package ccpd_pkg;

  // ----------------------------------------
  // mode decode, divider settings and lock states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ccpd_ratio_one,
    ccpd_ratio_half,
    ccpd_ratio_five
  } ccpd_ratio_t;

  typedef enum logic [1:0] {
    ccpd_div_full,
    ccpd_div_sixteenth,
    ccpd_div_stop
  } ccpd_div_t;

  typedef enum logic {
    ccpd_lock_ramp,
    ccpd_lock_track
  } ccpd_lock_t;

  typedef struct packed {
    logic feedback_on;
    logic pll_power;
    ccpd_ratio_t ratio;
  } ccpd_mode_t;

  // ----------------------------------------
  // encodings, widths and counts
  // ----------------------------------------
  localparam logic [1:0] CCPD_MODE_STATIC = 2'h0;
  localparam logic [1:0] CCPD_MODE_HALF = 2'h1;
  localparam logic [1:0] CCPD_MODE_ONE = 2'h2;
  localparam logic [1:0] CCPD_MODE_PLL = 2'h3;
  localparam logic [1:0] CCPD_SEL_FULL = 2'h0;
  localparam logic [1:0] CCPD_SEL_SIXTEENTH = 2'h1;
  localparam logic [1:0] CCPD_SEL_STOP = 2'h2;
  localparam int CCPD_PER_W = 16;
  localparam logic [CCPD_PER_W-1:0] CCPD_PLL_MULT = 16'h0005;
  localparam logic [7:0] CCPD_LOCK_LAST = 8'hFF;
  localparam logic [3:0] CCPD_SIXTEENTH_LAST = 4'hF;
  localparam int CCPD_INT_W = 4;

endpackage

// *** hw/ccpd_divider.sv ***
`timescale 1ns/1ps
`default_nettype none

module ccpd_divider (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_tick,
  input wire ccpd_pkg::ccpd_div_t i_sel,
  input wire logic i_wake,
  input wire logic i_sync_clr,
  output logic o_tick,
  output logic o_stopped
);

  ccpd_pkg::ccpd_div_t active_q, active_d;
  logic [3:0] cnt_q;
  wire is_full = (active_q == ccpd_pkg::ccpd_div_full);
  wire is_six = (active_q == ccpd_pkg::ccpd_div_sixteenth);
  wire is_stop = (active_q == ccpd_pkg::ccpd_div_stop);
  wire six_end = is_six && (cnt_q == ccpd_pkg::CCPD_SIXTEENTH_LAST);
  // settings change only between whole output periods or at once on sync clear
  // stop is left only through wake or sync clear
  wire boundary = is_full || (six_end && i_tick) || (is_six && cnt_q == 4'h0);
  wire keep_sel = (i_sel == ccpd_pkg::ccpd_div_stop) || (i_sel == ccpd_pkg::ccpd_div_sixteenth);

  assign o_tick = i_tick && (is_full || six_end);
  assign o_stopped = is_stop;

  always_comb begin
    active_d = active_q;
    if (i_sync_clr) begin
      active_d = ccpd_pkg::ccpd_div_full;
    end else if (is_stop && i_wake) begin
      active_d = ccpd_pkg::ccpd_div_full;
    end else if (boundary) begin
      active_d = keep_sel ? i_sel : ccpd_pkg::ccpd_div_full;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      active_q <= ccpd_pkg::ccpd_div_full;
      cnt_q <= 4'h0;
    end else begin
      active_q <= active_d;
      if (i_sync_clr || !is_six) begin
        cnt_q <= 4'h0;
      end else if (i_tick) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

endmodule

`default_nettype wire

// *** test/ccpd_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

module ccpd_checker (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_clock_mode_pin_a,
  input wire logic i_clock_mode_pin_b,
  input wire logic i_crystal_input,
  input wire logic [ccpd_pkg::CCPD_INT_W-1:0] i_int_pin_n,
  input wire logic o_crystal_drive_output,
  input wire logic o_pll_power_enable,
  input wire logic o_feedback_enable,
  input wire logic o_pll_locked,
  input wire logic o_clock_stopped,
  input wire logic o_primary_phase_clock,
  input wire logic o_secondary_phase_clock
);
  // ----------------------------------------
  // mode, lock, stop, phase and crystal drive checks
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_pll_pins;
    (i_clock_mode_pin_a && i_clock_mode_pin_b)[*4];
  endsequence
  sequence s_wake;
    o_clock_stopped && (i_int_pin_n != 4'hF);
  endsequence
  a_static_mode: assert property ((!i_clock_mode_pin_a && !i_clock_mode_pin_b)[*4] |->
    !o_feedback_enable && !o_pll_power_enable) else $error("static mode drives feedback or pll");
  a_ratio_mode: assert property ((i_clock_mode_pin_a ^ i_clock_mode_pin_b)[*4] |->
    o_feedback_enable && !o_pll_power_enable) else $error("ratio mode decode wrong");
  a_pll_mode: assert property (s_pll_pins |-> o_pll_power_enable && o_feedback_enable)
    else $error("pll mode decode wrong");
  a_lock_clear: assert property ((!(i_clock_mode_pin_a && i_clock_mode_pin_b))[*8] |-> !o_pll_locked)
    else $error("locked without pll power");
  a_lock_wait: assert property ($rose(o_pll_locked) |-> $past(o_pll_power_enable, 256))
    else $error("lock came too early");
  a_phase_pair: assert property (o_secondary_phase_clock == !o_primary_phase_clock)
    else $error("phase outputs not complementary");
  a_stop_still: assert property (o_clock_stopped[*3] |-> $stable(o_primary_phase_clock))
    else $error("phase moved while stopped");
  a_stop_wake: assert property (s_wake |-> ##[1:5] !o_clock_stopped)
    else $error("no wake on interrupt low");
  a_xtal_drive: assert property (o_crystal_drive_output |-> !$past(i_crystal_input, 3))
    else $error("crystal drive not inverse of input");
endmodule

`default_nettype wire

// *** test/ccpd_ref_src.sv ***
`timescale 1ns/1ps
`default_nettype none

module ccpd_ref_src #(
  parameter int HALF = 10
) (
  input wire logic i_mclk,
  input wire logic i_use_xtal,
  output logic o_ext,
  output logic o_xtal
);
  // ----------------------------------------
  // reference source, one of two inputs
  // ----------------------------------------
  int cnt_q = 0;
  logic lvl_q = 1'b0;
  always @(negedge i_mclk) begin
    cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
    if (cnt_q == HALF - 1) lvl_q <= !lvl_q;
  end
  assign o_ext = i_use_xtal ? 1'b0 : lvl_q;
  assign o_xtal = i_use_xtal ? lvl_q : 1'b0;
endmodule

`default_nettype wire

// *** test/tb_ccpd_clock_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_ccpd_clock_ctrl;
  // ----------------------------------------
  // stimulus and scoreboard
  // ----------------------------------------
  logic clk = 1'b0, rst = 1'b1, ma = 1'b1, mb = 1'b0, rpin_n = 1'b1, leg = 1'b0, use_x = 1'b0;
  logic meas = 1'b0, ext, xtal, xdrv, pll_on, fb_on, locked, stopped, ph1, ph3;
  logic [3:0] int_n = 4'hF;
  logic [1:0] sel = 2'h0;
  int errors = 0, samples_checked = 0, cyc = 0, r = 0, k = 0, exp_q[$];
  always #12.5 clk = ~clk;
  ccpd_ref_src u_src (.i_mclk(clk), .i_use_xtal(use_x), .o_ext(ext), .o_xtal(xtal));
  ccpd_clock_ctrl u_dut (.i_mclk(clk), .i_rst(rst), .i_clock_mode_pin_a(ma), .i_clock_mode_pin_b(mb),
    .i_external_ref_input(ext), .i_crystal_input(xtal), .i_reset_pin_n(rpin_n), .i_int_pin_n(int_n),
    .i_divide_sel(sel), .i_legacy_div2(leg), .o_crystal_drive_output(xdrv), .o_pll_power_enable(pll_on),
    .o_feedback_enable(fb_on), .o_pll_locked(locked), .o_clock_stopped(stopped),
    .o_primary_phase_clock(ph1), .o_secondary_phase_clock(ph3));
  task automatic end_of_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cmp_cnt(input int e, input int a);
    samples_checked++;
    if (a < e - 1 || a > e + 1) begin
      errors++;
      $display("[ERR] %0t exp %0h act %0h", $time, e, a);
    end
  endtask
  task automatic cmp_bit(input logic e, input logic a);
    samples_checked++;
    if (a !== e) begin
      errors++;
      $display("[ERR] %0t exp %0h act %0h", $time, e, a);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic measure(input int e);
    wait_n(40);
    exp_q.push_back(e);
    meas = 1'b1;
    wait_n(962);
    meas = 1'b0;
  endtask
  initial begin : mon
    int n;
    logic p;
    forever begin
      @(posedge meas);
      n = 0;
      p = ph1;
      repeat (960) begin
        @(posedge clk);
        #1;
        if (ph1 !== p) n++;
        p = ph1;
      end
      cmp_cnt(exp_q.pop_front(), n);
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(26));
    wait_n(12);
    rst = 1'b0;
    measure(48);
    ma = 1'b0;
    mb = 1'b1;
    measure(24);
    mb = 1'b0;
    use_x = 1'b1;
    wait_n(40);
    cmp_bit(1'b0, fb_on);
    cmp_bit(1'b0, xdrv);
    ma = 1'b1;
    measure(48);
    leg = 1'b1;
    measure(24);
    leg = 1'b0;
    sel = 2'h1;
    measure(3);
    sel = 2'h0;
    wait_n(400);
    sel = 2'h2;
    measure(0);
    sel = 2'h0;
    wait_n(40);
    cmp_bit(1'b1, stopped);
    r = $urandom % 5;
    for (int i = 0; i < 5; i++) begin
      k = (i + r) % 5;
      sel = 2'h2;
      wait_n(20);
      cmp_bit(1'b1, stopped);
      if (k == 4)
        rpin_n = 1'b0;
      else
        int_n[k[1:0]] = 1'b0;
      sel = 2'h0;
      wait_n(10);
      cmp_bit(1'b0, stopped);
      rpin_n = 1'b1;
      int_n = 4'hF;
    end
    mb = 1'b1;
    measure(24);
    wait_n(5200);
    cmp_bit(1'b1, locked);
    measure(240);
    mb = 1'b0;
    wait_n(40);
    cmp_bit(1'b0, locked);
    end_of_test();
  end
endmodule

bind ccpd_clock_ctrl ccpd_checker u_chk (.i_mclk, .i_rst, .i_clock_mode_pin_a, .i_clock_mode_pin_b,
  .i_crystal_input, .i_int_pin_n, .o_crystal_drive_output, .o_pll_power_enable, .o_feedback_enable,
  .o_pll_locked, .o_clock_stopped, .o_primary_phase_clock, .o_secondary_phase_clock);

`default_nettype wire
